// [logic/stes_defines.svh]
// constants for the serial transmit error supervisor
// assumes inclusion by bare name from design module and bench
`ifndef STES_DEFINES_SVH
`define STES_DEFINES_SVH
// register byte offsets
`define STES_OFS_CTRL 8'h00
`define STES_OFS_TIMEOUT 8'h04
`define STES_OFS_STATUS 8'h08
`define STES_OFS_CODE 8'h0C
`define STES_OFS_IRQ_STAT 8'h10
`define STES_OFS_IRQ_MASK 8'h14
`define STES_OFS_FAULT 8'h18
`define STES_OFS_INDICATOR 8'h1C
`define STES_OFS_VERSION 8'h20
`define STES_OFS_FREEZE 8'h24
// ctrl fields
`define STES_CTRL_PRIO_LO 0
`define STES_CTRL_DSR_CHK 2
`define STES_CTRL_CHAN_LO 4
// priority encodings
`define STES_PRIO_NONE 2'h0
`define STES_PRIO_LOCAL 2'h1
`define STES_PRIO_REMOTE 2'h2
// handler codes
`define STES_CODE_BROKEN 16'h4002
`define STES_CODE_BUSY 16'h4003
`define STES_CODE_PARAM 16'h4004
`define STES_CODE_SHUTDOWN 16'h4005
// system status codes
`define STES_CODE_REMOTE_PRIO 16'h2080
`define STES_CODE_NO_CTS 16'h2081
`define STES_CODE_NO_DSR 16'h2082
`define STES_CODE_BRK_TO 16'h2083
`define STES_CODE_CTS_TO 16'h2084
`define STES_CODE_DSR_TO 16'h2085
`define STES_CODE_RX_CANCEL 16'h1000
// indicator group letters
`define STES_LETTER_M 8'h4D
`define STES_LETTER_S 8'h53
// reset values
`define STES_TIMEOUT_RST 32'h0000_0064
`define STES_VERSION_NUM 8'h01
`define STES_REVISION_NUM 8'h00
// interrupt status bits
`define STES_IRQ_TXCODE 0
`define STES_IRQ_FAULT 1
`define STES_IRQ_DONE 2
`define STES_IRQ_STARTUP 3
`endif

// [logic/stes_pkg.sv]
// types for the serial transmit error supervisor
// assumes the defines header is on the include path
package stes_pkg;
    // supervisor states, gray along idle-wait-send-pause
    typedef enum logic [2:0] {
        STES_BOOT = 3'b000,
        STES_IDLE = 3'b001,
        STES_WAIT = 3'b011,
        STES_SEND = 3'b010,
        STES_PAUSE = 3'b110,
        STES_DEAD = 3'b111
    } stes_state_t;
    // why a send is paused
    typedef enum logic [1:0] {
        STES_WHY_BRK = 2'h0,
        STES_WHY_CTS = 2'h1,
        STES_WHY_DSR = 2'h2
    } stes_why_t;
    // modem and line events from the channel
    typedef struct packed {
        logic cts;
        logic dsr;
        logic rx_busy;
        logic brk_code;
        logic cont_code;
        logic tx_done;
    } stes_line_t;
    // whole module state
    typedef struct packed {
        stes_state_t st;
        stes_why_t why;
        logic [31:0] tmr;
        logic [7:0] ctrl;
        logic [31:0] timeout;
        logic [15:0] code;
        logic [15:0] hcode;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [15:0] fault;
        logic [3:0] fault_chan;
        logic [31:0] freeze;
        logic [31:0] indicator;
        logic err_led;
        logic rx_cancel;
        logic tx_start;
        logic [7:0] a_addr;
        logic a_wr;
        logic a_rd;
    } stes_state_s_t;
endpackage : stes_pkg

// [logic/stes_supervisor.sv]
// transmit error supervisor for one serial channel, AHB-Lite slave
// assumes line inputs synchronous to mclk and tables loaded before cfg_valid
//
// Behaviour
// - send while broken: reject, code 4002
// - send while sending: reject, code 4003
// - bad send parameters: reject, code 4004
// - send on shut channel: reject, code 4005
// - remote priority, receiving: wait, report 2080
// - no start without clear-to-send, 2081
// - checked dataset-ready absent: refuse, 2082
// - break pauses; continue resumes, else 2083
// - cts drop pauses; timeout aborts 2084
// - dsr drop pauses; timeout aborts 2085
// - local priority send cancels reception, 1000
// - codes to status; handler codes not shown
// - fault: led, freeze capture, channel stop
// - twelve distinct hardware fault kinds
// - host read parity fault names channel
// - indicator group M or S plus channel
// - startup message carries version and revision
// - tables load from store at reset
`timescale 1ns/1ns
`include "stes_defines.svh"
module stes_supervisor
    import stes_pkg::*;
#(
    parameter int MAX_LEN = 512
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // send request from host
    input wire logic send_req,
    input wire logic [15:0] send_len,
    output logic send_ack,
    output logic [15:0] send_code,
    // line side
    input wire stes_line_t line,
    output logic tx_start,
    output logic tx_enable,
    output logic rx_cancel,
    // faults and nonvolatile load
    input wire logic [11:0] hw_fault,
    input wire logic host_rd_parity,
    input wire logic cfg_valid,
    input wire logic [7:0] cfg_ctrl,
    input wire logic [31:0] cfg_timeout,
    input wire logic [31:0] diag_word,
    // indicators
    output logic err_led,
    output logic irq
);
    initial begin
        if (MAX_LEN < 1 || MAX_LEN > 65535) begin
            $error("MAX_LEN out of range");
        end
    end

    stes_state_s_t s_reg, s_next;

    // indicator text: group letter then channel digit
    function automatic logic [15:0] chan_tag(input logic [1:0] ch);
        chan_tag = {(ch[1] ? `STES_LETTER_S : `STES_LETTER_M), 8'h30 + {6'h00, ch}};
    endfunction : chan_tag

    // register readback, shared by bus data phase
    function automatic logic [31:0] rd_mux(input stes_state_s_t s, input logic [7:0] a);
        unique case (a)
            `STES_OFS_CTRL: rd_mux = {24'h000000, s.ctrl};
            `STES_OFS_TIMEOUT: rd_mux = s.timeout;
            `STES_OFS_STATUS: rd_mux = {24'h000000, s.why, 2'h0, s.err_led, s.st};
            `STES_OFS_CODE: rd_mux = {s.hcode, s.code};
            `STES_OFS_IRQ_STAT: rd_mux = {28'h0000000, s.irq_stat};
            `STES_OFS_IRQ_MASK: rd_mux = {28'h0000000, s.irq_mask};
            `STES_OFS_FAULT: rd_mux = {12'h000, s.fault_chan, s.fault};
            `STES_OFS_INDICATOR: rd_mux = s.indicator;
            `STES_OFS_VERSION: rd_mux = {16'h0000, `STES_VERSION_NUM, `STES_REVISION_NUM};
            `STES_OFS_FREEZE: rd_mux = s.freeze;
            default: rd_mux = 32'h00000000;
        endcase
    endfunction : rd_mux

    logic [1:0] chan;
    logic [1:0] prio;
    logic tmo;
    logic [3:0] ev;
    assign chan = s_reg.ctrl[`STES_CTRL_CHAN_LO +: 2];
    assign prio = s_reg.ctrl[`STES_CTRL_PRIO_LO +: 2];
    assign tmo = (s_reg.tmr >= s_reg.timeout);

    // next-state for all supervisor state
    always_comb begin
        logic ok;
        s_next = s_reg;
        ok = 1'b0;
        s_next.tx_start = 1'b0;
        s_next.rx_cancel = 1'b0;
        ev = 4'h0;
        // bus address phase capture
        s_next.a_wr = hsel && hready && htrans[1] && hwrite;
        s_next.a_rd = hsel && hready && htrans[1] && !hwrite;
        if (hsel && hready && htrans[1]) begin
            s_next.a_addr = haddr[7:0];
        end
        // host writes in the data phase
        if (s_reg.a_wr) begin
            unique case (s_reg.a_addr)
                `STES_OFS_CTRL: s_next.ctrl = hwdata[7:0];
                `STES_OFS_TIMEOUT: s_next.timeout = hwdata;
                `STES_OFS_IRQ_MASK: s_next.irq_mask = hwdata[3:0];
                `STES_OFS_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~hwdata[3:0];
                default: ;
            endcase
        end
        // send request screening, highest priority first
        if (send_req) begin
            if (s_reg.st == STES_DEAD || s_reg.st == STES_BOOT) begin
                s_next.hcode = `STES_CODE_SHUTDOWN;
            end else if (send_len == 16'h0000 || 32'(send_len) > MAX_LEN) begin
                s_next.hcode = `STES_CODE_PARAM;
            end else if (s_reg.st == STES_PAUSE) begin
                s_next.hcode = `STES_CODE_BROKEN;
            end else if (s_reg.st != STES_IDLE) begin
                s_next.hcode = `STES_CODE_BUSY;
            end else begin
                s_next.hcode = 16'h0000;
                s_next.st = STES_WAIT;
            end
        end
        s_next.tmr = s_reg.tmr + 32'h00000001;
        unique case (s_reg.st)
            STES_BOOT: begin
                // tables come from the store, then startup message
                if (cfg_valid) begin
                    s_next.ctrl = cfg_ctrl;
                    s_next.timeout = cfg_timeout;
                    s_next.st = STES_IDLE;
                    s_next.indicator = {chan_tag(cfg_ctrl[`STES_CTRL_CHAN_LO +: 2]),
                        `STES_VERSION_NUM, `STES_REVISION_NUM};
                    ev[`STES_IRQ_STARTUP] = 1'b1;
                end
            end
            STES_IDLE: ;
            STES_WAIT: begin
                // start checks; codes reported while refused
                if (prio == `STES_PRIO_REMOTE && line.rx_busy) begin
                    s_next.code = `STES_CODE_REMOTE_PRIO;
                end else if (!line.cts) begin
                    s_next.code = `STES_CODE_NO_CTS;
                end else if (s_reg.ctrl[`STES_CTRL_DSR_CHK] && !line.dsr) begin
                    s_next.code = `STES_CODE_NO_DSR;
                    s_next.st = STES_IDLE;
                end else begin
                    s_next.st = STES_SEND;
                    s_next.tx_start = 1'b1;
                    if (prio == `STES_PRIO_LOCAL && line.rx_busy) begin
                        s_next.rx_cancel = 1'b1;
                        s_next.code = `STES_CODE_RX_CANCEL;
                    end
                end
                if (s_next.code != s_reg.code) begin
                    ev[`STES_IRQ_TXCODE] = 1'b1;
                end
            end
            STES_SEND: begin
                // a break, cts loss or checked dsr loss pauses and restarts the send timeout
                s_next.tmr = 32'h00000000;
                if (line.tx_done) begin
                    s_next.st = STES_IDLE;
                    ev[`STES_IRQ_DONE] = 1'b1;
                end else if (line.brk_code) begin
                    s_next.st = STES_PAUSE;
                    s_next.why = STES_WHY_BRK;
                end else if (!line.cts) begin
                    s_next.st = STES_PAUSE;
                    s_next.why = STES_WHY_CTS;
                end else if (s_reg.ctrl[`STES_CTRL_DSR_CHK] && !line.dsr) begin
                    s_next.st = STES_PAUSE;
                    s_next.why = STES_WHY_DSR;
                end
            end
            STES_PAUSE: begin
                // resume when the cause clears, else abort on timeout
                unique case (s_reg.why)
                    STES_WHY_BRK: ok = line.cont_code;
                    STES_WHY_CTS: ok = line.cts;
                    default: ok = line.dsr;
                endcase
                if (ok && !line.cts) begin
                    // cause gone but cts still low: wait on cts, same timer
                    s_next.why = STES_WHY_CTS;
                end else if (ok) begin
                    s_next.st = STES_SEND;
                end else if (tmo) begin
                    s_next.st = STES_IDLE;
                    ev[`STES_IRQ_TXCODE] = 1'b1;
                    unique case (s_reg.why)
                        STES_WHY_BRK: s_next.code = `STES_CODE_BRK_TO;
                        STES_WHY_CTS: s_next.code = `STES_CODE_CTS_TO;
                        default: s_next.code = `STES_CODE_DSR_TO;
                    endcase
                end
            end
            STES_DEAD: ;
            default: s_next.st = STES_DEAD;
        endcase
        if (s_reg.st == STES_WAIT || s_reg.st == STES_IDLE) begin
            s_next.tmr = 32'h00000000;
        end
        // hardware faults win over every state change and freeze the channel
        if ((hw_fault != 12'h000 || host_rd_parity) && s_reg.st != STES_DEAD) begin
            s_next.st = STES_DEAD;
            s_next.err_led = 1'b1;
            s_next.freeze = diag_word;
            s_next.fault = {3'h0, host_rd_parity, hw_fault};
            s_next.fault_chan = {2'h0, chan};
            s_next.indicator = {chan_tag(chan), 16'h0000};
            ev[`STES_IRQ_FAULT] = 1'b1;
        end
        // sticky status: set wins over write-one-clear
        s_next.irq_stat = s_next.irq_stat | ev;
        // handler codes are never shown, only system codes
        if (ev[`STES_IRQ_TXCODE]) begin
            s_next.indicator = {chan_tag(chan), s_next.code};
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.st <= STES_BOOT;
            s_reg.timeout <= `STES_TIMEOUT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs; slave is zero-wait and always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_reg.a_rd ? rd_mux(s_reg, s_reg.a_addr) : 32'h00000000;
    assign send_ack = send_req;
    assign send_code = s_reg.hcode;
    assign tx_start = s_reg.tx_start;
    assign tx_enable = (s_reg.st == STES_SEND);
    assign rx_cancel = s_reg.rx_cancel;
    assign err_led = s_reg.err_led;
    assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

    // checks
    property p_busy_reject;
        @(posedge mclk) disable iff (!nrst)
        (send_req && s_reg.st == STES_SEND && send_len != 16'h0000
            && 32'(send_len) <= MAX_LEN)
            |=> send_code == `STES_CODE_BUSY;
    endproperty
    a_busy_reject: assert property (p_busy_reject)
        else $error("busy code missing");
    property p_broken_reject;
        @(posedge mclk) disable iff (!nrst)
        (send_req && s_reg.st == STES_PAUSE && send_len != 16'h0000
            && 32'(send_len) <= MAX_LEN)
            |=> send_code == `STES_CODE_BROKEN;
    endproperty
    a_broken_reject: assert property (p_broken_reject)
        else $error("broken code missing");
    property p_param_reject;
        @(posedge mclk) disable iff (!nrst)
        (send_req && s_reg.st == STES_IDLE && send_len == 16'h0000)
            |=> send_code == `STES_CODE_PARAM && s_reg.st == STES_IDLE;
    endproperty
    a_param_reject: assert property (p_param_reject)
        else $error("param code missing");
    property p_dead_reject;
        @(posedge mclk) disable iff (!nrst)
        (send_req && s_reg.st == STES_DEAD) |=> send_code == `STES_CODE_SHUTDOWN;
    endproperty
    a_dead_reject: assert property (p_dead_reject)
        else $error("shutdown code missing");
    property p_no_cts;
        @(posedge mclk) disable iff (!nrst)
        $rose(tx_enable) |-> $past(line.cts);
    endproperty
    a_no_cts: assert property (p_no_cts)
        else $error("send began without cts");
    property p_fault_stop;
        @(posedge mclk) disable iff (!nrst)
        (hw_fault != 12'h000) |=> err_led && !tx_enable ##1 err_led && !tx_enable;
    endproperty
    a_fault_stop: assert property (p_fault_stop)
        else $error("fault did not stop channel");
    property p_cts_pause;
        @(posedge mclk) disable iff (!nrst)
        (s_reg.st == STES_SEND && !line.cts && !line.tx_done && !line.brk_code
            && hw_fault == 12'h000 && !host_rd_parity)
            |=> s_reg.st == STES_PAUSE && s_reg.why == STES_WHY_CTS;
    endproperty
    a_cts_pause: assert property (p_cts_pause)
        else $error("cts drop did not pause");
    property p_local_cancel;
        @(posedge mclk) disable iff (!nrst)
        $rose(rx_cancel) |-> tx_start && s_reg.code == `STES_CODE_RX_CANCEL;
    endproperty
    a_local_cancel: assert property (p_local_cancel)
        else $error("cancel without code");
    // an unmasked event must show on irq the next cycle, even against a clear
    property p_irq_level;
        @(posedge mclk) disable iff (!nrst)
        (ev & s_next.irq_mask) != 4'h0 |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not raised");
    property p_remote_hold;
        @(posedge mclk) disable iff (!nrst)
        (s_reg.st == STES_WAIT && prio == `STES_PRIO_REMOTE && line.rx_busy)
            |=> !tx_enable && s_reg.code == `STES_CODE_REMOTE_PRIO;
    endproperty
    a_remote_hold: assert property (p_remote_hold)
        else $error("remote priority not kept");
    property p_dsr_refuse;
        @(posedge mclk) disable iff (!nrst)
        (s_reg.st == STES_WAIT && s_reg.ctrl[`STES_CTRL_DSR_CHK] && line.cts
            && !line.dsr && !line.rx_busy)
            |=> !tx_enable && s_reg.code == `STES_CODE_NO_DSR;
    endproperty
    a_dsr_refuse: assert property (p_dsr_refuse)
        else $error("sent without dataset ready");
    // a break left unanswered for the whole timeout must end the send
    property p_brk_abort;
        @(posedge mclk) disable iff (!nrst)
        (s_reg.st == STES_PAUSE && s_reg.why == STES_WHY_BRK && !line.cont_code
            && s_reg.tmr >= s_reg.timeout && hw_fault == 12'h000 && !host_rd_parity)
            |=> s_reg.st == STES_IDLE && s_reg.code == `STES_CODE_BRK_TO;
    endproperty
    a_brk_abort: assert property (p_brk_abort)
        else $error("break timeout missed");
    property p_startup;
        @(posedge mclk) disable iff (!nrst)
        (s_reg.st == STES_BOOT && cfg_valid && hw_fault == 12'h000 && !host_rd_parity)
            |=> s_reg.st == STES_IDLE
            && s_reg.indicator[15:0] == {`STES_VERSION_NUM, `STES_REVISION_NUM};
    endproperty
    a_startup: assert property (p_startup)
        else $error("startup message missing");
endmodule : stes_supervisor

// [sim/stes_remote.sv]
// remote serial station model: modem lines, break/continue codes, end of frame
// assumes bench knobs change right after a rising mclk edge
`timescale 1ns/1ns
module stes_remote
    import stes_pkg::*;
(
    // clock
    input wire logic mclk,
    // bench knobs
    input wire logic cts_on,
    input wire logic dsr_on,
    input wire logic rx_on,
    input wire logic brk_cmd,
    input wire logic cont_cmd,
    input wire logic [7:0] done_after,
    // supervisor side
    input wire logic tx_enable,
    output stes_line_t line
);
    logic [7:0] sent;
    // count sending cycles; a pause restarts the frame count
    always_ff @(posedge mclk) begin
        sent <= tx_enable ? sent + 8'h01 : 8'h00;
    end
    // done_after of zero keeps the frame open until the supervisor aborts
    always_comb begin
        line.cts = cts_on;
        line.dsr = dsr_on;
        line.rx_busy = rx_on;
        line.brk_code = brk_cmd;
        line.cont_code = cont_cmd;
        line.tx_done = tx_enable && (done_after != 8'h00) && (sent == done_after);
    end
endmodule : stes_remote

// [sim/test_serial_tx_error_supervisor.sv]
// self-checking bench for the transmit error supervisor
// assumes an always-ready slave and a send timeout loaded as 12 cycles
`timescale 1ns/1ns
`include "stes_defines.svh"
module test_serial_tx_error_supervisor import stes_pkg::*;;
    localparam int LEN_MAX = 512;
    localparam logic [31:0] LO = 32'h0000FFFF;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic mclk, nrst, hsel, hwrite, hreadyout, hresp, send_req, send_ack;
    logic [31:0] haddr, hwdata, hrdata, cfg_timeout, diag_word;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] send_len, send_code;
    logic [11:0] hw_fault;
    logic [7:0] cfg_ctrl, done_after;
    logic tx_start, tx_enable, rx_cancel, err_led, irq, cfg_valid, host_rd_parity;
    logic cts_on, dsr_on, rx_on, brk_cmd, cont_cmd, rd_phase, sent_prev;
    stes_line_t line;
    int errors, checked, cycles, starts, cancels, s0;
    logic [63:0] code_q[$];
    logic [63:0] rd_q[$];

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    stes_supervisor #(.MAX_LEN(LEN_MAX)) dut (.mclk(mclk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .send_req(send_req), .send_len(send_len), .send_ack(send_ack),
        .send_code(send_code), .line(line), .tx_start(tx_start), .tx_enable(tx_enable),
        .rx_cancel(rx_cancel), .hw_fault(hw_fault), .host_rd_parity(host_rd_parity),
        .cfg_valid(cfg_valid), .cfg_ctrl(cfg_ctrl), .cfg_timeout(cfg_timeout),
        .diag_word(diag_word), .err_led(err_led), .irq(irq));

    stes_remote far (.mclk(mclk), .cts_on(cts_on), .dsr_on(dsr_on), .rx_on(rx_on),
        .brk_cmd(brk_cmd), .cont_cmd(cont_cmd), .done_after(done_after),
        .tx_enable(tx_enable), .line(line));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    task automatic cmp(input logic [31:0] got, input logic [63:0] e);
        checked++;
        if ((got & e[63:32]) !== e[31:0]) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got & e[63:32], e[31:0]);
        end
    endtask : cmp

    task automatic lvl(input logic s, input logic v);
        cmp({31'h0, s}, {32'h1, 31'h0, v});
    endtask : lvl

    // results show a cycle after their cause, so notes are taken off in order
    always @(negedge mclk) begin
        if (sent_prev) cmp({16'h0000, send_code}, code_q.pop_front());
        if (rd_phase) cmp(hrdata, rd_q.pop_front());
        if (tx_start === 1'b1) starts++;
        if (rx_cancel === 1'b1) cancels++;
        sent_prev <= send_req;
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic send(input logic [15:0] len, input logic [15:0] code);
        code_q.push_back({LO, 16'h0000, code});
        send_len <= len;
        send_req <= 1'b1;
        tick(1);
        lvl(send_ack, 1'b1);
        send_req <= 1'b0;
        tick(1);
    endtask : send

    // single word transfer; d is write data or expected read data
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
                       input logic [31:0] m);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, ofs};
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_phase <= !wr;
        if (!wr) rd_q.push_back({m, d & m});
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        lvl(hresp, 1'b0);
        rd_phase <= 1'b0;
    endtask : ahb

    task automatic wait_tx(input logic v);
        int n;
        n = 0;
        while (tx_enable !== v && n < 40) begin
            tick(1);
            n++;
        end
        lvl(tx_enable, v);
    endtask : wait_tx

    task automatic modem(input logic c, input logic d);
        cts_on <= c;
        dsr_on <= d;
    endtask : modem

    task automatic pulse(input logic cont);
        if (cont) cont_cmd <= 1'b1;
        else brk_cmd <= 1'b1;
        tick(1);
        brk_cmd <= 1'b0;
        cont_cmd <= 1'b0;
    endtask : pulse

    task automatic boot(input logic load, input logic [7:0] ctrl);
        nrst <= 1'b0;
        tick(4);
        nrst <= 1'b1;
        tick(1);
        if (load) begin
            cfg_ctrl <= ctrl;
            cfg_valid <= 1'b1;
            tick(1);
            cfg_valid <= 1'b0;
            tick(1);
        end
    endtask : boot

    // main sequence
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        send_req = 1'b0;
        send_len = 16'h0;
        hw_fault = 12'h000;
        host_rd_parity = 1'b0;
        cfg_valid = 1'b0;
        cfg_ctrl = 8'h00;
        cfg_timeout = 32'h0000000C;
        cts_on = 1'b1;
        dsr_on = 1'b1;
        rx_on = 1'b0;
        brk_cmd = 1'b0;
        cont_cmd = 1'b0;
        done_after = 8'h08;
        rd_phase = 1'b0;
        sent_prev = 1'b0;
        void'($urandom(32'hFBF62899));
        diag_word = $urandom;
        boot(1'b0, 8'h00);
        send(16'h0010, `STES_CODE_SHUTDOWN);
        boot(1'b1, 8'h00);
        ahb(1'b0, `STES_OFS_TIMEOUT, 32'h0000000C, ALL);
        ahb(1'b0, `STES_OFS_IRQ_STAT, 32'h8, 32'h8);
        ahb(1'b0, `STES_OFS_INDICATOR, {`STES_LETTER_M, 8'h30, `STES_VERSION_NUM,
            `STES_REVISION_NUM}, ALL);
        ahb(1'b0, 8'h40, 32'h0, ALL);
        ahb(1'b1, `STES_OFS_IRQ_STAT, 32'h8, 32'h0);
        ahb(1'b0, `STES_OFS_IRQ_STAT, 32'h0, 32'h8);
        send(16'h0000, `STES_CODE_PARAM);
        send(16'(LEN_MAX + 1 + ($urandom % 100)), `STES_CODE_PARAM);
        ahb(1'b0, `STES_OFS_CODE, {`STES_CODE_PARAM, 16'h0000}, ALL);
        $display("test 1 done");
        s0 = starts;
        send(16'(1 + ($urandom % LEN_MAX)), 16'h0000);
        wait_tx(1'b1);
        send(16'h0004, `STES_CODE_BUSY);
        wait_tx(1'b0);
        cmp(starts - s0, {ALL, 32'h1});
        done_after <= 8'h00;
        send(16'h0020, 16'h0000);
        wait_tx(1'b1);
        pulse(1'b0);
        wait_tx(1'b0);
        send(16'h0020, `STES_CODE_BROKEN);
        pulse(1'b1);
        wait_tx(1'b1);
        pulse(1'b0);
        tick(20);
        lvl(tx_enable, 1'b0);
        ahb(1'b0, `STES_OFS_CODE, {16'h0, `STES_CODE_BRK_TO}, LO);
        $display("test 2 done");
        ahb(1'b1, `STES_OFS_CTRL, 32'h4, 32'h0);
        for (int k = 0; k < 2; k++) begin
            send(16'h0020, 16'h0000);
            wait_tx(1'b1);
            modem(k[0], !k[0]);
            wait_tx(1'b0);
            tick(3);
            modem(1'b1, 1'b1);
            wait_tx(1'b1);
            modem(k[0], !k[0]);
            tick(20);
            modem(1'b1, 1'b1);
            ahb(1'b0, `STES_OFS_CODE,
                {16'h0, k ? `STES_CODE_DSR_TO : `STES_CODE_CTS_TO}, LO);
        end
        done_after <= 8'h04;
        modem(1'b0, 1'b1);
        send(16'h0020, 16'h0000);
        tick(4);
        lvl(tx_enable, 1'b0);
        ahb(1'b0, `STES_OFS_CODE, {16'h0, `STES_CODE_NO_CTS}, LO);
        modem(1'b1, 1'b1);
        wait_tx(1'b1);
        wait_tx(1'b0);
        modem(1'b1, 1'b0);
        send(16'h0020, 16'h0000);
        ahb(1'b0, `STES_OFS_CODE, {16'h0, `STES_CODE_NO_DSR}, LO);
        modem(1'b1, 1'b1);
        tick(4);
        lvl(tx_enable, 1'b0);
        $display("test 3 done");
        ahb(1'b1, `STES_OFS_CTRL, 32'h6, 32'h0);
        rx_on <= 1'b1;
        send(16'h0020, 16'h0000);
        tick(4);
        lvl(tx_enable, 1'b0);
        ahb(1'b0, `STES_OFS_CODE, {16'h0, `STES_CODE_REMOTE_PRIO}, LO);
        rx_on <= 1'b0;
        wait_tx(1'b1);
        wait_tx(1'b0);
        ahb(1'b1, `STES_OFS_CTRL, 32'h5, 32'h0);
        rx_on <= 1'b1;
        s0 = cancels;
        send(16'h0020, 16'h0000);
        tick(4);
        rx_on <= 1'b0;
        cmp(cancels - s0, {ALL, 32'h1});
        ahb(1'b0, `STES_OFS_CODE, {16'h0, `STES_CODE_RX_CANCEL}, LO);
        wait_tx(1'b0);
        ahb(1'b1, `STES_OFS_IRQ_MASK, 32'h1, 32'h0);
        tick(1);
        lvl(irq, 1'b1);
        ahb(1'b1, `STES_OFS_IRQ_STAT, 32'hF, 32'h0);
        tick(1);
        lvl(irq, 1'b0);
        modem(1'b0, 1'b1);
        send(16'h0020, 16'h0000);
        tick(2);
        lvl(irq, 1'b1);
        modem(1'b1, 1'b1);
        wait_tx(1'b0);
        ahb(1'b1, `STES_OFS_IRQ_MASK, 32'h0, 32'h0);
        tick(1);
        lvl(irq, 1'b0);
        $display("test 4 done");
        // every fault kind on its own, channel 2 shows group S
        for (int k = 0; k < 12; k++) begin
            boot(1'b1, 8'h20);
            hw_fault <= 12'h001 << k;
            tick(1);
            hw_fault <= 12'h000;
            tick(2);
            lvl(err_led, 1'b1);
            send(16'h0010, `STES_CODE_SHUTDOWN);
            ahb(1'b0, `STES_OFS_FAULT, {16'h0002, 4'h0, 12'h001 << k}, ALL);
        end
        ahb(1'b0, `STES_OFS_INDICATOR, {`STES_LETTER_S, 24'h0}, 32'hFF000000);
        ahb(1'b0, `STES_OFS_IRQ_STAT, 32'h2, 32'h2);
        ahb(1'b0, `STES_OFS_FREEZE, diag_word, ALL);
        boot(1'b1, 8'h10);
        host_rd_parity <= 1'b1;
        tick(1);
        host_rd_parity <= 1'b0;
        tick(2);
        ahb(1'b0, `STES_OFS_INDICATOR, {`STES_LETTER_M, 8'h31, 16'h0}, 32'hFFFF0000);
        ahb(1'b0, `STES_OFS_FAULT, 32'h0001_1000, ALL);
        $display("test 5 done");
        close_out();
    end
endmodule : test_serial_tx_error_supervisor
